// ### eecp_pkg.sv
// constants, types and helpers of the spi eeprom command and protection block
package eecp_pkg;
   localparam logic [7:0] OP_STATUS_WR = 8'h01;
   localparam logic [7:0] OP_WRITE_A = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_STATUS_RD = 8'h05;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_WRITE_B = 8'h07;
   localparam logic [7:0] OP_POLL = 8'h08;
   localparam logic [7:0] POLL_BUSY = 8'hff;
   localparam logic [7:0] POLL_IDLE = 8'h00;
   localparam logic [2:0] RSV_BUSY = 3'h7;
   localparam logic [2:0] RSV_IDLE = 3'h0;
   localparam int ST_PEN = 7;
   localparam int ST_BPH = 3;
   localparam int ST_BPL = 2;
   localparam int ADDR_W = 18;
   localparam int BYTE_W = 8;
   localparam logic [1:0] ADDR_LAST = 2'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QTR = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_ALL = 2'h3;
   localparam logic [17:0] QTR_BASE = 18'h30000;
   localparam logic [17:0] HALF_BASE = 18'h20000;
   localparam int T_WC_NS = 10000000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int WC_CYC = T_WC_NS / CLK_PERIOD_NS;
   localparam int FIFO_DEPTH = 16;
   // pin sampler lanes and their idle levels
   localparam int PIN_SI = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_CS = 2;
   localparam int PIN_WP = 3;
   localparam logic [3:0] PIN_RST = 4'hc;

   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_OPC = 8'h02,
      S_ADDR = 8'h04,
      S_RDATA = 8'h08,
      S_WDATA = 8'h10,
      S_SWDATA = 8'h20,
      S_SOUT = 8'h40,
      S_SKIP = 8'h80
   } eecp_state_t;

   function automatic logic blk_prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
      case (bp)
         BP_QTR: blk_prot = (a >= QTR_BASE);
         BP_HALF: blk_prot = (a >= HALF_BASE);
         BP_ALL: blk_prot = 1'b1;
         default: blk_prot = 1'b0;
      endcase
   endfunction

   function automatic logic is_array_write(input logic [7:0] op);
      is_array_write = (op == OP_WRITE_A) || (op == OP_WRITE_B);
   endfunction
endpackage

// ### eecp_fifo_if.sv
// carrier between the command engine and the write fifo
`timescale 1ns/100ps
interface eecp_fifo_if #(parameter int W = 26);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   logic flush;
   modport src (output in_valid, output in_data, output out_ready, output flush,
                input in_ready, input out_valid, input out_data);
   modport buf_side (input in_valid, input in_data, input out_ready, input flush,
                     output in_ready, output out_valid, output out_data);
endinterface

// ### eecp_fifo.sv
// write data fifo, address and byte per word
`timescale 1ns/100ps
module eecp_fifo #(
   parameter int W = 26,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   eecp_fifo_if.buf_side f
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_ff [DEPTH];
   logic [PW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic do_wr, do_rd;

   assign f.in_ready = (wp_ff - rp_ff) != (PW+1)'(DEPTH);
   assign f.out_valid = wp_ff != rp_ff;
   assign f.out_data = mem_ff[rp_ff[PW-1:0]];
   assign do_wr = f.in_valid && f.in_ready;
   assign do_rd = f.out_valid && f.out_ready;

   always_comb begin
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      // flush drops an aborted frame's bytes
      if (f.flush) begin
         nxt_rp = wp_ff;
      end else begin
         if (do_wr) nxt_wp = wp_ff + 1'b1;
         if (do_rd) nxt_rp = rp_ff + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_ff <= '0;
         rp_ff <= '0;
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
      end
   end

   always_ff @(posedge clk) begin
      if (do_wr && !f.flush) mem_ff[wp_ff[PW-1:0]] <= f.in_data;
   end
endmodule // eecp_fifo

// ### eecp_mem.sv
// byte array with registered read port
`timescale 1ns/100ps
module eecp_mem #(
   parameter int AW = 18,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data
);
   logic [DW-1:0] cell_ff [2**AW];

   always_ff @(posedge clk) begin
      if (wr_en) cell_ff[wr_addr] <= wr_data;
      if (rd_en) rd_data <= cell_ff[rd_addr];
   end
endmodule // eecp_mem

// ### eecp_top.sv
// spi eeprom command decoder, write protection and write cycle timer
`timescale 1ns/100ps
module eecp_top #(
   parameter int WRITE_CYC = eecp_pkg::WC_CYC,
   parameter int FIFO_DEPTH = eecp_pkg::FIFO_DEPTH
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic SPI_SCK,
   input wire logic SPI_CS_N,
   input wire logic SPI_SI,
   input wire logic WP_N,
   output logic SPI_SO,
   output logic SPI_SO_OE,
   output logic [7:0] STATUS,
   output logic BUSY,
   output logic WRITE_LATCH
);
   localparam int AW = eecp_pkg::ADDR_W;
   localparam int FW = eecp_pkg::ADDR_W + eecp_pkg::BYTE_W;
   localparam int CW = $clog2(WRITE_CYC + 1);

   logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
   logic sck_rise, sck_fall, cs_fall, cs_rise, in_frame, si_s, wp_low, hw_prot;
   eecp_pkg::eecp_state_t state_ff, nxt_state;
   logic [2:0] bit_cnt_ff, nxt_bit_cnt;
   logic [6:0] shin_ff, nxt_shin;
   logic [7:0] op_ff, nxt_op, out_sh_ff, nxt_out_sh, sw_data_ff, nxt_sw_data;
   logic [AW-1:0] addr_ff, nxt_addr, rd_addr;
   logic [1:0] abyte_ff, nxt_abyte, bp_ff, nxt_bp;
   logic so_ff, nxt_so, arm_ff, nxt_arm, latch_ff, nxt_latch, busy_ff, nxt_busy;
   logic pen_ff, nxt_pen, pend_ff, nxt_pend, mem_rd, byte_done, push, flush;
   logic [CW-1:0] wc_cnt_ff, nxt_wc_cnt;
   logic [7:0] in_byte, rd_data, status_val, poll_val;

   eecp_fifo_if #(.W(FW)) wq ();

   // pins come from the master's domain: two flops, then a third for edges
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pin_s1_ff <= eecp_pkg::PIN_RST;
         pin_s2_ff <= eecp_pkg::PIN_RST;
         pin_s3_ff <= eecp_pkg::PIN_RST;
      end else begin
         pin_s1_ff <= {WP_N, SPI_CS_N, SPI_SCK, SPI_SI};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   assign in_frame = !pin_s2_ff[eecp_pkg::PIN_CS];
   assign cs_fall = in_frame && pin_s3_ff[eecp_pkg::PIN_CS];
   assign cs_rise = !in_frame && !pin_s3_ff[eecp_pkg::PIN_CS];
   assign sck_rise = in_frame && pin_s2_ff[eecp_pkg::PIN_SCK] && !pin_s3_ff[eecp_pkg::PIN_SCK];
   assign sck_fall = in_frame && !pin_s2_ff[eecp_pkg::PIN_SCK] && pin_s3_ff[eecp_pkg::PIN_SCK];
   assign si_s = pin_s2_ff[eecp_pkg::PIN_SI];
   assign wp_low = !pin_s2_ff[eecp_pkg::PIN_WP];
   assign hw_prot = pen_ff && wp_low;
   assign in_byte = {shin_ff, si_s};
   assign byte_done = sck_rise && (bit_cnt_ff == eecp_pkg::BIT_LAST);
   assign status_val = {pen_ff, busy_ff ? eecp_pkg::RSV_BUSY : eecp_pkg::RSV_IDLE,
                        bp_ff, latch_ff, busy_ff};
   assign poll_val = busy_ff ? eecp_pkg::POLL_BUSY : eecp_pkg::POLL_IDLE;

   always_comb begin
      nxt_state = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shin = shin_ff;
      nxt_op = op_ff;
      nxt_addr = addr_ff;
      nxt_abyte = abyte_ff;
      nxt_out_sh = out_sh_ff;
      nxt_so = so_ff;
      nxt_arm = arm_ff;
      nxt_latch = latch_ff;
      nxt_busy = busy_ff;
      nxt_wc_cnt = wc_cnt_ff;
      nxt_pen = pen_ff;
      nxt_bp = bp_ff;
      nxt_sw_data = sw_data_ff;
      nxt_pend = 1'b0;
      mem_rd = 1'b0;
      rd_addr = addr_ff;
      push = 1'b0;
      flush = 1'b0;
      if (busy_ff) begin
         if (wc_cnt_ff == CW'(WRITE_CYC - 1)) begin
            nxt_busy = 1'b0;
            nxt_latch = 1'b0;
            nxt_wc_cnt = '0;
         end else begin
            nxt_wc_cnt = wc_cnt_ff + 1'b1;
         end
      end
      if (pend_ff) nxt_out_sh = rd_data;
      if (cs_fall) begin
         nxt_state = eecp_pkg::S_OPC;
         nxt_bit_cnt = '0;
         nxt_arm = 1'b0;
      end else if (cs_rise) begin
         nxt_state = eecp_pkg::S_IDLE;
         nxt_arm = 1'b0;
         flush = 1'b1;
         // commands take effect only at a byte boundary on release
         if (arm_ff) begin
            case (op_ff)
               eecp_pkg::OP_SET_LATCH: nxt_latch = 1'b1;
               eecp_pkg::OP_CLR_LATCH: nxt_latch = 1'b0;
               eecp_pkg::OP_STATUS_WR: begin
                  if (latch_ff && !hw_prot) begin
                     nxt_pen = sw_data_ff[eecp_pkg::ST_PEN];
                     nxt_bp = sw_data_ff[eecp_pkg::ST_BPH:eecp_pkg::ST_BPL];
                     nxt_busy = 1'b1;
                     nxt_wc_cnt = '0;
                  end
               end
               eecp_pkg::OP_WRITE_A, eecp_pkg::OP_WRITE_B: begin
                  if (latch_ff) begin
                     nxt_busy = 1'b1;
                     nxt_wc_cnt = '0;
                     flush = 1'b0;
                  end
               end
               default: nxt_arm = 1'b0;
            endcase
         end
      end else if (sck_rise) begin
         nxt_shin = in_byte[6:0];
         nxt_bit_cnt = bit_cnt_ff + 1'b1;
         nxt_arm = 1'b0;
         if (byte_done) begin
            case (state_ff)
               eecp_pkg::S_OPC: begin
                  nxt_op = in_byte;
                  nxt_abyte = '0;
                  nxt_state = eecp_pkg::S_SKIP;
                  if (busy_ff && in_byte != eecp_pkg::OP_STATUS_RD
                      && in_byte != eecp_pkg::OP_POLL) begin
                     nxt_state = eecp_pkg::S_SKIP;
                  end else begin
                     case (in_byte)
                        eecp_pkg::OP_STATUS_RD: begin
                           nxt_state = eecp_pkg::S_SOUT;
                           nxt_out_sh = status_val;
                        end
                        eecp_pkg::OP_POLL: begin
                           nxt_state = eecp_pkg::S_SOUT;
                           nxt_out_sh = poll_val;
                        end
                        eecp_pkg::OP_SET_LATCH, eecp_pkg::OP_CLR_LATCH: nxt_arm = 1'b1;
                        eecp_pkg::OP_STATUS_WR: begin
                           if (latch_ff) nxt_state = eecp_pkg::S_SWDATA;
                        end
                        eecp_pkg::OP_READ: nxt_state = eecp_pkg::S_ADDR;
                        eecp_pkg::OP_WRITE_A, eecp_pkg::OP_WRITE_B: begin
                           if (latch_ff) nxt_state = eecp_pkg::S_ADDR;
                        end
                        default: nxt_state = eecp_pkg::S_SKIP;
                     endcase
                  end
               end
               eecp_pkg::S_ADDR: begin
                  // upper address bits simply shift out of the top
                  nxt_addr = {addr_ff[AW-eecp_pkg::BYTE_W-1:0], in_byte};
                  nxt_abyte = abyte_ff + 1'b1;
                  if (abyte_ff == eecp_pkg::ADDR_LAST) begin
                     if (op_ff == eecp_pkg::OP_READ) begin
                        nxt_state = eecp_pkg::S_RDATA;
                        mem_rd = 1'b1;
                        rd_addr = nxt_addr;
                     end else begin
                        nxt_state = eecp_pkg::S_WDATA;
                     end
                  end
               end
               eecp_pkg::S_RDATA: begin
                  nxt_addr = addr_ff + 1'b1;
                  mem_rd = 1'b1;
                  rd_addr = nxt_addr;
               end
               eecp_pkg::S_WDATA: begin
                  // protected bytes are dropped, the rest of the page still goes
                  push = !eecp_pkg::blk_prot(addr_ff, bp_ff);
                  nxt_addr = {addr_ff[AW-1:eecp_pkg::BYTE_W],
                              addr_ff[eecp_pkg::BYTE_W-1:0] + 1'b1};
                  nxt_arm = 1'b1;
               end
               eecp_pkg::S_SWDATA: begin
                  nxt_sw_data = in_byte;
                  nxt_arm = 1'b1;
                  nxt_state = eecp_pkg::S_SKIP;
               end
               eecp_pkg::S_SOUT: nxt_out_sh = (op_ff == eecp_pkg::OP_POLL) ? poll_val
                                                                         : status_val;
               default: nxt_state = state_ff;
            endcase
         end
      end else if (sck_fall) begin
         nxt_so = out_sh_ff[7];
         nxt_out_sh = {out_sh_ff[6:0], 1'b0};
      end
      nxt_pend = mem_rd;
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_ff <= eecp_pkg::S_IDLE;
         bit_cnt_ff <= '0;
         shin_ff <= '0;
         op_ff <= '0;
         addr_ff <= '0;
         abyte_ff <= '0;
         out_sh_ff <= '0;
         so_ff <= 1'b0;
         arm_ff <= 1'b0;
         latch_ff <= 1'b0;
         busy_ff <= 1'b0;
         wc_cnt_ff <= '0;
         pen_ff <= 1'b0;
         bp_ff <= eecp_pkg::BP_NONE;
         sw_data_ff <= '0;
         pend_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         shin_ff <= nxt_shin;
         op_ff <= nxt_op;
         addr_ff <= nxt_addr;
         abyte_ff <= nxt_abyte;
         out_sh_ff <= nxt_out_sh;
         so_ff <= nxt_so;
         arm_ff <= nxt_arm;
         latch_ff <= nxt_latch;
         busy_ff <= nxt_busy;
         wc_cnt_ff <= nxt_wc_cnt;
         pen_ff <= nxt_pen;
         bp_ff <= nxt_bp;
         sw_data_ff <= nxt_sw_data;
         pend_ff <= nxt_pend;
      end
   end

   // array is only programmed while the write cycle runs; the fifo backs up otherwise
   assign wq.in_valid = push;
   assign wq.in_data = {addr_ff, in_byte};
   assign wq.out_ready = busy_ff;
   assign wq.flush = flush;

   eecp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .f(wq)
   );

   eecp_mem #(.AW(AW), .DW(eecp_pkg::BYTE_W)) u_mem (
      .clk(REF_CLK),
      .rd_en(mem_rd),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .wr_en(wq.out_valid && busy_ff),
      .wr_addr(wq.out_data[FW-1:eecp_pkg::BYTE_W]),
      .wr_data(wq.out_data[eecp_pkg::BYTE_W-1:0])
   );

   assign SPI_SO = so_ff;
   assign SPI_SO_OE = in_frame && (state_ff == eecp_pkg::S_SOUT || state_ff == eecp_pkg::S_RDATA);
   assign STATUS = status_val;
   assign BUSY = busy_ff;
   assign WRITE_LATCH = latch_ff;

   property p_poll_val;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (byte_done && state_ff == eecp_pkg::S_SOUT && op_ff == eecp_pkg::OP_POLL)
      |=> out_sh_ff == ($past(busy_ff) ? eecp_pkg::POLL_BUSY : eecp_pkg::POLL_IDLE);
   endproperty
   a_poll_val: assert property (p_poll_val) else $error("poll byte wrong");

   property p_set_latch;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (cs_rise && arm_ff && op_ff == eecp_pkg::OP_SET_LATCH) |=> latch_ff;
   endproperty
   a_set_latch: assert property (p_set_latch) else $error("latch not set");

   property p_latch_reset;
      @(posedge REF_CLK) $fell(SYS_RST) |-> !latch_ff && !busy_ff;
   endproperty
   a_latch_reset: assert property (p_latch_reset) else $error("latch set after reset");

   property p_clr_latch;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (cs_rise && arm_ff && op_ff == eecp_pkg::OP_CLR_LATCH) |=> !latch_ff;
   endproperty
   a_clr_latch: assert property (p_clr_latch) else $error("latch not cleared");

   property p_hw_block;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (cs_rise && op_ff == eecp_pkg::OP_STATUS_WR && (hw_prot || !latch_ff))
      |=> $stable(pen_ff) && $stable(bp_ff) && !$rose(busy_ff);
   endproperty
   a_hw_block: assert property (p_hw_block) else $error("status write not blocked");

   property p_start_cycle;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (cs_rise && arm_ff && latch_ff && eecp_pkg::is_array_write(op_ff)) |=> busy_ff ##1 busy_ff;
   endproperty
   a_start_cycle: assert property (p_start_cycle) else $error("write cycle not started");

   property p_end_cycle;
      @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(busy_ff) |-> !latch_ff && $past(wc_cnt_ff) == CW'(WRITE_CYC - 1);
   endproperty
   a_end_cycle: assert property (p_end_cycle) else $error("write cycle end wrong");

   property p_busy_ignore;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (byte_done && state_ff == eecp_pkg::S_OPC && busy_ff && in_byte != eecp_pkg::OP_STATUS_RD
       && in_byte != eecp_pkg::OP_POLL) |=> state_ff == eecp_pkg::S_SKIP && !arm_ff;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

   property p_read_inc;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (byte_done && state_ff == eecp_pkg::S_RDATA) |=> addr_ff == AW'($past(addr_ff) + 1'b1);
   endproperty
   a_read_inc: assert property (p_read_inc) else $error("read address not advanced");

   property p_no_prot_push;
      @(posedge REF_CLK) disable iff (SYS_RST)
      wq.in_valid && wq.in_ready |-> state_ff == eecp_pkg::S_WDATA && latch_ff
                                      && !eecp_pkg::blk_prot(addr_ff, bp_ff);
   endproperty
   a_no_prot_push: assert property (p_no_prot_push) else $error("protected byte queued");

   c_poll: cover property (@(posedge REF_CLK) byte_done && state_ff == eecp_pkg::S_SOUT && busy_ff);
   c_read: cover property (@(posedge REF_CLK) byte_done && state_ff == eecp_pkg::S_RDATA);
   c_arr_write: cover property (@(posedge REF_CLK) cs_rise && arm_ff && latch_ff
                                && eecp_pkg::is_array_write(op_ff));
   c_sr_block: cover property (@(posedge REF_CLK) cs_rise && op_ff == eecp_pkg::OP_STATUS_WR && hw_prot);
endmodule // eecp_top

// ### eecp_spi_master.sv
// spi master model standing on the far side of the eeprom command port, mode 0
`timescale 1ns/100ps
module eecp_spi_master (
   output logic SCK,
   output logic CS_N,
   output logic SI,
   input wire logic SO
);
   initial begin
      SCK = 1'b0;
      CS_N = 1'b1;
      SI = 1'b0;
   end
   // whole bytes only; sck rests low outside frames
   task automatic xfer(input logic [63:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0;
      CS_N = 1'b0;
      #62.5;
      for (int i = 0; i < 8 * n; i++) begin
         SI = tx[63 - i];
         #62.5;
         SCK = 1'b1;
         rx = {rx[14:0], SO};
         #62.5;
         SCK = 1'b0;
      end
      #31.5;
      // release right after the last bit so the command is taken
      CS_N = 1'b1;
      // released data line must not keep showing the last bit
      SI = ~SI;
      #100;
   endtask
endmodule // eecp_spi_master

// ### tb.sv
// self-checking bench of the eeprom command and protection block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
   logic ref_clk;
   logic sys_rst;
   logic wp_n;
   wire sck, cs_n, si, so, so_oe, busy, latch;
   wire so_line;
   wire [7:0] status;
   logic [15:0] rx;
   int n_errors = 0;
   int samples_checked = 0;
   logic [1:0] bp;
   logic [17:0] a;
   logic p;
   // block level, address, expected protected
   logic [20:0] rows [5] = '{{2'h0, 18'h3ffff, 1'h0}, {2'h1, 18'h2ffff, 1'h0},
      {2'h1, 18'h30000, 1'h1}, {2'h2, 18'h20000, 1'h1}, {2'h3, 18'h00000, 1'h1}};
   // long enough to poll twice while busy
   eecp_top #(.WRITE_CYC(1500), .FIFO_DEPTH(16)) DUT (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_SI(si), .WP_N(wp_n), .SPI_SO(so),
      .SPI_SO_OE(so_oe), .STATUS(status), .BUSY(busy), .WRITE_LATCH(latch));
   // so floats to its pull-up whenever the block lets go of it
   assign so_line = so_oe ? so : 1'b1;
   eecp_spi_master m (.SCK(sck), .CS_N(cs_n), .SI(si), .SO(so_line));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic stop_test;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk);
      `CHK("idle", 1'b0, busy)
      #1;
   endtask
   task automatic wr_status(input logic [7:0] v);
      m.xfer({8'h06, 56'h0}, 1, rx);
      m.xfer({8'h01, v, 48'h0}, 2, rx);
      wait_idle();
   endtask
   task automatic wr_byte(input logic [7:0] op, input logic [17:0] ad, input logic [7:0] d);
      m.xfer({8'h06, 56'h0}, 1, rx);
      m.xfer({op, 6'h00, ad, d, 24'h0}, 5, rx);
      wait_idle();
   endtask
   task automatic rd(input logic [17:0] ad, input int n);
      m.xfer({8'h03, 6'h3f, ad, 32'h0}, 4 + n, rx);
   endtask
   initial begin
      #380000;
      n_errors++;
      stop_test();
   end
   initial begin
      sys_rst = 1'b1;
      wp_n = 1'b1;
      repeat (16) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge ref_clk);
      `CHK("status", 8'h00, status)
      `CHK("latch", 1'b0, latch)
      foreach (rows[i]) begin
         {bp, a, p} = rows[i];
         wr_status(8'h00);
         wr_byte(8'h02, a, 8'h5a);
         wr_status({4'h0, bp, 2'h0});
         m.xfer({8'h05, 56'h0}, 2, rx);
         `CHK("status", ({4'h0, bp, 2'h0}), rx[7:0])
         wr_byte(i[0] ? 8'h07 : 8'h02, a, 8'ha5);
         rd(a, 1);
         `CHK("data", p ? 8'h5a : 8'ha5, rx[7:0])
      end
      rd(18'h3ffff, 2);
      `CHK("wrap", 16'ha55a, rx)
      wr_status(8'h00);
      m.xfer({8'h02, 6'h00, 18'h00000, 8'h11, 24'h0}, 5, rx);
      `CHK("busy", 1'b0, busy)
      rd(18'h00000, 1);
      `CHK("data", 8'h5a, rx[7:0])
      m.xfer({8'h01, 8'h8c, 48'h0}, 2, rx);
      `CHK("busy", 1'b0, busy)
      `CHK("status", 8'h00, status)
      m.xfer({8'h06, 56'h0}, 1, rx);
      `CHK("latch", 1'b1, latch)
      m.xfer({8'h04, 56'h0}, 1, rx);
      `CHK("latch", 1'b0, latch)
      wr_status(8'h80);
      @(posedge ref_clk);
      #1 wp_n = 1'b0;
      m.xfer({8'h06, 56'h0}, 1, rx);
      m.xfer({8'h01, 8'h00, 48'h0}, 2, rx);
      wait_idle();
      `CHK("status", 8'h82, status)
      m.xfer({8'h04, 56'h0}, 1, rx);
      `CHK("latch", 1'b0, latch)
      @(posedge ref_clk);
      #1 wp_n = 1'b1;
      wr_status(8'h00);
      `CHK("status", 8'h00, status)
      m.xfer({8'h06, 56'h0}, 1, rx);
      m.xfer({8'h02, 6'h00, 18'h00100, 8'h33, 24'h0}, 5, rx);
      m.xfer({8'h04, 56'h0}, 1, rx);
      `CHK("latch", 1'b1, latch)
      // status read still answered mid-cycle, reserved bits show ones
      m.xfer({8'h05, 56'h0}, 2, rx);
      `CHK("status", 8'h73, rx[7:0])
      m.xfer({8'h08, 56'h0}, 3, rx);
      `CHK("poll", 16'hffff, rx)
      wait_idle();
      `CHK("latch", 1'b0, latch)
      m.xfer({8'h08, 56'h0}, 3, rx);
      `CHK("poll", 16'h0000, rx)
      `CHK("oe", 1'b0, so_oe)
      stop_test();
   end
endmodule // tb
